//--- design/dcap_pkg.sv
// Shared constants and carrier types for the data cache array port
package dcap_pkg;

  // ----------------------------------------
  // Geometry
  // ----------------------------------------
  localparam int WAYS       = 4;
  localparam int ENTRIES    = 128;
  localparam int ENT_W      = 7;
  localparam int IDX_W      = 8;
  localparam int WAY_W      = 2;
  localparam int LINE_BYTES = 16;
  localparam int LINE_W     = 144;
  localparam int DW_W       = 64;
  localparam int PAR_W      = 8;
  localparam int PAR_LSB    = 128;
  localparam int HALF_BIT   = 0;

  // ----------------------------------------
  // Repair registers
  // ----------------------------------------
  localparam int REP_REGS  = 4;
  localparam int REP_ADR_W = 2;
  localparam int REP_VAL_W = 6;
  localparam int REP_EN_W  = 2;
  localparam logic [REP_VAL_W-1:0] REP_VAL_RST = 6'h00;
  localparam logic [REP_EN_W-1:0]  REP_EN_RST  = 2'h0;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic             rd_vld;
    logic             wr_vld;
    logic             idx_sel;
    logic [IDX_W-1:0] rd_idx;
    logic [IDX_W-1:0] alt_idx;
    logic [WAY_W-1:0] wr_way;
    logic             bypass_n;
  } dcap_req_t;

  typedef struct packed {
    logic [LINE_W-1:0]     data;
    logic [LINE_BYTES-1:0] mask;
  } dcap_wr_t;

  typedef struct packed {
    logic [REP_ADR_W-1:0] addr;
    logic [REP_VAL_W-1:0] value;
    logic [REP_EN_W-1:0]  en;
    logic                 wr;
    logic                 clr;
  } dcap_rep_t;

  typedef enum logic [1:0] {
    OP_NOOP,
    OP_READ,
    OP_WRITE,
    OP_CLASH
  } dcap_op_t;

endpackage

//--- design/dcap_port.sv
// Port logic of the four-way data cache array
`timescale 1ns/10ps

module dcap_port
(
  input  wire logic                      clk_in,
  input  wire logic                      reset_n_in,
  input  wire dcap_pkg::dcap_req_t       req_in,
  input  wire dcap_pkg::dcap_wr_t        wr_in,
  input  wire logic [3:0]                rsel_way_in,
  input  wire logic [3:0]                alt_rsel_way_in,
  input  wire logic                      alt_way_sel_in,
  input  wire logic [63:0]               fill_bypass_data_in,
  input  wire logic                      array_clk_en_in,
  input  wire logic                      write_clk_en_in,
  input  wire logic                      read_clk_en_in,
  input  wire logic                      clock_header_override_in,
  input  wire logic                      input_collar_scan_enable_in,
  input  wire logic                      output_collar_scan_enable_in,
  input  wire logic                      array_scan_enable_in,
  input  wire logic                      array_write_inhibit_in,
  input  wire dcap_pkg::dcap_rep_t       repair_in,
  output logic      [63:0]               rdata_out,
  output logic      [7:0]                rparity_out,
  output logic                           way0_parity_error_out,
  output logic                           way1_parity_error_out,
  output logic                           way2_parity_error_out,
  output logic                           way3_parity_error_out,
  output logic      [7:0]                way0_byte_top_bits_out,
  output logic      [7:0]                way1_byte_top_bits_out,
  output logic      [7:0]                way2_byte_top_bits_out,
  output logic      [7:0]                way3_byte_top_bits_out,
  output logic      [5:0]                repair_value_out,
  output logic      [1:0]                repair_en_out
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] par_fn(input logic [63:0] d);
    logic [7:0] p;
    p = 8'h00;
    for (int b = 0; b < 8; b++)
    begin
      p[b] = ^d[b*8 +: 8];
    end
    return p;
  endfunction

  function automatic logic [7:0] msb_fn(input logic [63:0] d);
    logic [7:0] m;
    m = 8'h00;
    for (int b = 0; b < 8; b++)
    begin
      m[b] = d[b*8+7];
    end
    return m;
  endfunction

  // ----------------------------------------
  // Local enables
  // ----------------------------------------
  // Scan shift is not modelled; a collar in scan simply holds
  logic in_en;
  logic wr_en;
  logic out_en;
  logic arr_en;

  assign arr_en = array_clk_en_in | clock_header_override_in;
  assign in_en  = arr_en & ~input_collar_scan_enable_in;
  assign wr_en  = (write_clk_en_in | clock_header_override_in) & ~input_collar_scan_enable_in;
  assign out_en = (read_clk_en_in | clock_header_override_in) & ~output_collar_scan_enable_in;

  // ----------------------------------------
  // Input collar (access stage)
  // ----------------------------------------
  dcap_pkg::dcap_req_t req_q;
  dcap_pkg::dcap_wr_t  wdat_q;
  logic                arr_on_q;

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      req_q          <= '0;
      req_q.bypass_n <= 1'b1;
      arr_on_q       <= 1'b0;
    end
    else
    begin
      arr_on_q <= arr_en;
      if (in_en)
      begin
        req_q <= req_in;
      end
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      wdat_q <= '0;
    end
    else if (wr_en)
    begin
      wdat_q <= wr_in;
    end
  end

  // ----------------------------------------
  // Access decode
  // ----------------------------------------
  dcap_pkg::dcap_op_t           op_m;
  logic [dcap_pkg::IDX_W-1:0]   idx_m;
  logic [dcap_pkg::ENT_W-1:0]   ent_m;
  logic                         rd_go_m;
  logic                         wr_go_m;

  assign idx_m = req_q.idx_sel ? req_q.alt_idx : req_q.rd_idx;
  assign ent_m = idx_m[dcap_pkg::IDX_W-1:1];

  always_comb
  begin
    case ({req_q.rd_vld, req_q.wr_vld})
      2'b10:   op_m = dcap_pkg::OP_READ;
      2'b01:   op_m = dcap_pkg::OP_WRITE;
      2'b11:   op_m = dcap_pkg::OP_CLASH;
      default: op_m = dcap_pkg::OP_NOOP;
    endcase
  end

  // A clash or a scanned array neither reads nor writes the array
  assign rd_go_m = (op_m == dcap_pkg::OP_READ) & arr_on_q & ~array_scan_enable_in;
  assign wr_go_m = (op_m == dcap_pkg::OP_WRITE) & arr_on_q & ~array_scan_enable_in
                   & ~array_write_inhibit_in;

  // ----------------------------------------
  // Array
  // ----------------------------------------
  // Storage is not reset; contents are undefined until written
  logic [dcap_pkg::LINE_W-1:0] mem_q [dcap_pkg::WAYS][dcap_pkg::ENTRIES];

  always_ff @(posedge clk_in)
  begin
    if (wr_go_m)
    begin
      for (int b = 0; b < dcap_pkg::LINE_BYTES; b++)
      begin
        if (wdat_q.mask[b])
        begin
          mem_q[req_q.wr_way][ent_m][b*8 +: 8] <= wdat_q.data[b*8 +: 8];
          mem_q[req_q.wr_way][ent_m][dcap_pkg::PAR_LSB+b] <= wdat_q.data[dcap_pkg::PAR_LSB+b];
        end
      end
    end
  end

  logic [63:0] dw_m [dcap_pkg::WAYS];
  logic [7:0]  pw_m [dcap_pkg::WAYS];

  always_comb
  begin
    for (int w = 0; w < dcap_pkg::WAYS; w++)
    begin
      if (idx_m[dcap_pkg::HALF_BIT])
      begin
        dw_m[w] = mem_q[w][ent_m][127:64];
        pw_m[w] = mem_q[w][ent_m][143:136];
      end
      else
      begin
        dw_m[w] = mem_q[w][ent_m][63:0];
        pw_m[w] = mem_q[w][ent_m][135:128];
      end
    end
  end

  // ----------------------------------------
  // Output collar (result stage)
  // ----------------------------------------
  logic [63:0] dw_q   [dcap_pkg::WAYS];
  logic [7:0]  pw_q   [dcap_pkg::WAYS];
  logic [7:0]  msb_q  [dcap_pkg::WAYS];
  logic [3:0]  perr_q;
  logic [63:0] fill_q;
  logic        byp_n_q;
  logic [3:0]  alt_rsel_q;
  logic        alt_sel_q;

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      for (int w = 0; w < dcap_pkg::WAYS; w++)
      begin
        dw_q[w]  <= 64'h0000000000000000;
        pw_q[w]  <= 8'h00;
        msb_q[w] <= 8'h00;
      end
      perr_q <= 4'h0;
    end
    else if (out_en)
    begin
      for (int w = 0; w < dcap_pkg::WAYS; w++)
      begin
        // Non-read cycles load zero so the output mux reads zero
        dw_q[w]   <= rd_go_m ? dw_m[w] : 64'h0000000000000000;
        pw_q[w]   <= rd_go_m ? pw_m[w] : 8'h00;
        msb_q[w]  <= rd_go_m ? msb_fn(dw_m[w]) : 8'h00;
        perr_q[w] <= rd_go_m & (par_fn(dw_m[w]) != pw_m[w]);
      end
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      fill_q     <= 64'h0000000000000000;
      byp_n_q    <= 1'b1;
      alt_rsel_q <= 4'h0;
      alt_sel_q  <= 1'b0;
    end
    else if (out_en)
    begin
      fill_q     <= fill_bypass_data_in;
      byp_n_q    <= req_q.bypass_n;
      alt_rsel_q <= alt_rsel_way_in;
      alt_sel_q  <= alt_way_sel_in;
    end
  end

  // ----------------------------------------
  // Read output mux
  // ----------------------------------------
  // Multi-hot selects OR ways together; the controller keeps them one-hot
  logic [3:0]  sel_b;
  logic [63:0] mux_d;
  logic [7:0]  mux_p;

  assign sel_b = alt_sel_q ? alt_rsel_q : rsel_way_in;

  always_comb
  begin
    mux_d = 64'h0000000000000000;
    mux_p = 8'h00;
    for (int w = 0; w < dcap_pkg::WAYS; w++)
    begin
      mux_d = mux_d | (dw_q[w] & {64{sel_b[w]}});
      mux_p = mux_p | (pw_q[w] & {8{sel_b[w]}});
    end
  end

  // Fill data carries no parity bits, so they are made here
  assign rdata_out   = byp_n_q ? mux_d : fill_q;
  assign rparity_out = byp_n_q ? mux_p : par_fn(fill_q);

  assign way0_parity_error_out  = perr_q[0];
  assign way1_parity_error_out  = perr_q[1];
  assign way2_parity_error_out  = perr_q[2];
  assign way3_parity_error_out  = perr_q[3];
  assign way0_byte_top_bits_out = msb_q[0];
  assign way1_byte_top_bits_out = msb_q[1];
  assign way2_byte_top_bits_out = msb_q[2];
  assign way3_byte_top_bits_out = msb_q[3];

  // ----------------------------------------
  // Repair registers
  // ----------------------------------------
  dcap_pkg::dcap_rep_t         rep_q;
  logic [dcap_pkg::REP_VAL_W-1:0] rval_q [dcap_pkg::REP_REGS];
  logic [dcap_pkg::REP_EN_W-1:0]  ren_q  [dcap_pkg::REP_REGS];
  logic [dcap_pkg::REP_VAL_W-1:0] rval_out_q;
  logic [dcap_pkg::REP_EN_W-1:0]  ren_out_q;

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      rep_q <= '0;
    end
    else if (~input_collar_scan_enable_in)
    begin
      rep_q <= repair_in;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      for (int r = 0; r < dcap_pkg::REP_REGS; r++)
      begin
        rval_q[r] <= dcap_pkg::REP_VAL_RST;
        ren_q[r]  <= dcap_pkg::REP_EN_RST;
      end
    end
    else if (rep_q.clr)
    begin
      for (int r = 0; r < dcap_pkg::REP_REGS; r++)
      begin
        rval_q[r] <= dcap_pkg::REP_VAL_RST;
        ren_q[r]  <= dcap_pkg::REP_EN_RST;
      end
    end
    else if (rep_q.wr)
    begin
      rval_q[rep_q.addr] <= rep_q.value;
      ren_q[rep_q.addr]  <= rep_q.en;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      rval_out_q <= dcap_pkg::REP_VAL_RST;
      ren_out_q  <= dcap_pkg::REP_EN_RST;
    end
    else if (rep_q.clr)
    begin
      rval_out_q <= dcap_pkg::REP_VAL_RST;
      ren_out_q  <= dcap_pkg::REP_EN_RST;
    end
    else if (!rep_q.wr)
    begin
      rval_out_q <= rval_q[rep_q.addr];
      ren_out_q  <= ren_q[rep_q.addr];
    end
  end

  assign repair_value_out = rval_out_q;
  assign repair_en_out    = ren_out_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);

  property p_clash_zero;
    (op_m == dcap_pkg::OP_CLASH) && out_en && req_q.bypass_n && (sel_b == sel_b)
      |=> (rdata_out == 64'h0000000000000000) && (rparity_out == 8'h00);
  endproperty
  a_clash_zero: assert property (p_clash_zero) else $error("clash cycle gave read data");

  property p_no_sel_zero;
    byp_n_q && (sel_b == 4'h0) |-> (rdata_out == 64'h0000000000000000) && (rparity_out == 8'h00);
  endproperty
  a_no_sel_zero: assert property (p_no_sel_zero) else $error("no way selected but data nonzero");

  property p_bypass;
    (in_en && !req_in.bypass_n) ##1 out_en |=> rdata_out == $past(fill_bypass_data_in);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass did not drive fill data");

  property p_inhibit;
    array_write_inhibit_in |=> mem_q[$past(req_q.wr_way)][$past(ent_m)]
                               == $past(mem_q[req_q.wr_way][ent_m]);
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("array written under inhibit");

  property p_full_write;
    wr_go_m && (wdat_q.mask == 16'hFFFF)
      |=> mem_q[$past(req_q.wr_way)][$past(ent_m)] == $past(wdat_q.data);
  endproperty
  a_full_write: assert property (p_full_write) else $error("full byte mask write lost data");

  property p_perr;
    rd_go_m && out_en && (par_fn(dw_m[0]) != pw_m[0]) |=> way0_parity_error_out;
  endproperty
  a_perr: assert property (p_perr) else $error("way 0 parity error missed");

  property p_msb;
    rd_go_m && out_en |=> way1_byte_top_bits_out == $past(msb_fn(dw_m[1]));
  endproperty
  a_msb: assert property (p_msb) else $error("way 1 byte top bits wrong");

  property p_index;
    in_en |=> ent_m == $past(req_in.idx_sel ? req_in.alt_idx[7:1] : req_in.rd_idx[7:1]);
  endproperty
  a_index: assert property (p_index) else $error("wrong index selected");

  property p_rep_clear;
    repair_in.clr && !input_collar_scan_enable_in |=> ##1 (rval_q[0] == 6'h00) && (ren_q[3] == 2'h0);
  endproperty
  a_rep_clear: assert property (p_rep_clear) else $error("repair reset did not clear");

  property p_rep_read;
    !rep_q.wr && !rep_q.clr |=> repair_value_out == $past(rval_q[rep_q.addr]);
  endproperty
  a_rep_read: assert property (p_rep_read) else $error("repair read returned wrong value");

endmodule

//--- tb/dcap_tag_hit_model.sv
// Stand-in for the tag-hit logic that feeds the normal read way select
`timescale 1ns/10ps

module dcap_tag_hit_model
(
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  input  wire logic [3:0] hit_in,
  output logic      [3:0] rsel_way_out
);
  // ----------------------------------------
  // Hit pipeline
  // ----------------------------------------
  logic [3:0] hit_m_q;
  logic [3:0] hit_b_q;

  // Select shows up one stage after the access, unregistered at the array
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      hit_m_q <= 4'h0;
      hit_b_q <= 4'h0;
    end
    else
    begin
      hit_m_q <= hit_in;
      hit_b_q <= hit_m_q;
    end
  end

  // Caller hands over one-hot or zero hits only
  assign rsel_way_out = hit_b_q;
endmodule

//--- tb/tb_data_cache_array_port.sv
// Self-checking bench for the data cache array port
`timescale 1ns/10ps

module tb_data_cache_array_port;
  logic                clk_in;
  logic                reset_n_in;
  dcap_pkg::dcap_req_t req;
  dcap_pkg::dcap_wr_t  wrq;
  dcap_pkg::dcap_rep_t rep;
  logic [3:0]          hit;
  logic [3:0]          rsel;
  logic [3:0]          alt_rsel;
  logic                alt_sel;
  logic                ace;
  logic                wce;
  logic                rce;
  logic                ovr;
  logic                inh;
  logic                ase;
  logic                ics;
  logic [63:0]         fill;
  logic [63:0]         fd;
  logic [63:0]         rdata;
  logic [7:0]          rpar;
  logic [3:0]          perr;
  logic [7:0]          top [4];
  logic [5:0]          rval;
  logic [1:0]          ren;
  logic [143:0]        wd;
  logic [15:0]         wm;
  logic [143:0]        refm [4][128];
  int                  errors;
  int                  check_count;
  int                  cycles = 0;

  dcap_tag_hit_model hit_u (.clk_in(clk_in), .reset_n_in(reset_n_in), .hit_in(hit), .rsel_way_out(rsel));

  dcap_port dut_u
  (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .req_in(req), .wr_in(wrq), .rsel_way_in(rsel),
    .alt_rsel_way_in(alt_rsel), .alt_way_sel_in(alt_sel), .fill_bypass_data_in(fill),
    .array_clk_en_in(ace), .write_clk_en_in(wce), .read_clk_en_in(rce), .clock_header_override_in(ovr),
    .input_collar_scan_enable_in(ics), .output_collar_scan_enable_in(1'b0), .array_scan_enable_in(ase),
    .array_write_inhibit_in(inh), .repair_in(rep), .rdata_out(rdata), .rparity_out(rpar),
    .way0_parity_error_out(perr[0]), .way1_parity_error_out(perr[1]),
    .way2_parity_error_out(perr[2]), .way3_parity_error_out(perr[3]),
    .way0_byte_top_bits_out(top[0]), .way1_byte_top_bits_out(top[1]),
    .way2_byte_top_bits_out(top[2]), .way3_byte_top_bits_out(top[3]),
    .repair_value_out(rval), .repair_en_out(ren)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] par16(input logic [127:0] d);
    logic [15:0] p;
    for (int b = 0; b < 16; b++)
      p[b] = ^d[8*b+:8];
    return p;
  endfunction

  // Byte top bits alternate so a lane swap shows
  function automatic logic [143:0] line(input int w, input int e);
    logic [127:0] d;
    for (int b = 0; b < 16; b++)
      d[8*b+:8] = 8'(((b & 1) << 7) | (w << 4) | ((b + e) & 15));
    return {par16(d), d};
  endfunction

  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    check_count++;
    if (g !== e)
    begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  // One access: request in c0, late controls in c1, outputs judged in c2
  task automatic acc(input logic rv, input logic wv, input logic [7:0] i, input logic [1:0] wy,
                     input logic [3:0] sel, input logic alt, input logic byp, input logic ih);
    @(posedge clk_in);
    req <= '{rd_vld:rv, wr_vld:wv, idx_sel:alt, rd_idx:(alt ? ~i : i), alt_idx:(alt ? i : ~i),
             wr_way:wy, bypass_n:~byp};
    wrq <= '{data:wd, mask:wm};
    hit <= alt ? 4'h0 : sel;
    @(posedge clk_in);
    req <= '{bypass_n:1'b1, default:'0};
    hit <= 4'h0;
    alt_rsel <= sel;
    alt_sel <= alt;
    fill <= fd;
    inh <= ih;
    if (wv && !rv && !ih && !ase && !ics && (ace || ovr) && (wce || ovr))
      for (int b = 0; b < 16; b++)
        if (wm[b])
        begin
          refm[wy][i[7:1]][8*b+:8] = wd[8*b+:8];
          refm[wy][i[7:1]][128+b] = wd[128+b];
        end
    @(posedge clk_in);
    inh <= 1'b0;
    #1;
  endtask

  task automatic cw(input logic [7:0] i, input int w);
    logic [143:0] l;
    logic [15:0] p;
    logic [7:0] t;
    for (int k = 0; k < 4; k++)
    begin
      l = refm[k][i[7:1]];
      p = par16(l[127:0]);
      for (int b = 0; b < 8; b++)
        t[b] = l[64*i[0]+8*b+7];
      chk("top_bits", t, top[k]);
      chk("parity_error", |(l[128+8*i[0]+:8] ^ p[8*i[0]+:8]), perr[k]);
      if (k == w)
      begin
        chk("rdata", l[64*i[0]+:64], rdata);
        chk("rparity", l[128+8*i[0]+:8], rpar);
      end
    end
  endtask

  task automatic rd(input logic [7:0] i, input int w, input logic alt);
    acc(1'b1, 1'b0, i, 2'h0, 4'(1 << w), alt, 1'b0, 1'b0);
    cw(i, w);
  endtask

  task automatic wr(input logic [7:0] i, input logic [1:0] w, input logic ih);
    acc(1'b0, 1'b1, i, w, 4'h0, 1'b1, 1'b0, ih);
  endtask

  task automatic rp(input logic [1:0] a, input logic [5:0] v, input logic [1:0] en, input logic w,
                    input logic c);
    @(posedge clk_in);
    rep <= '{addr:a, value:v, en:en, wr:w, clr:c};
    @(posedge clk_in);
    rep <= '{addr:a, default:'0};
    @(posedge clk_in);
    #1;
  endtask

  task automatic results();
    $display("Checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // Clock, timeout and main sequence
  // ----------------------------------------
  initial
  begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  // Whole run is under two hundred cycles
  always @(posedge clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      errors++;
      results();
    end
  end

  initial
  begin
    logic [15:0] pp;
    reset_n_in = 1'b0;
    req = '{bypass_n:1'b1, default:'0};
    wrq = '0;
    rep = '0;
    {hit, alt_rsel, alt_sel, ovr, inh, ase, ics, fill, wd, wm} = '0;
    {ace, wce, rce} = 3'h7;
    fd = 64'h0123_4567_89AB_CDEF;
    errors = 0;
    check_count = 0;
    repeat (10) @(posedge clk_in);
    reset_n_in <= 1'b1;
    #1;
    chk("repair_value", 6'h00, rval);
    chk("repair_en", 2'h0, ren);
    wm = 16'hFFFF;
    for (int w = 0; w < 4; w++)
      for (int e = 5; e < 128; e += 122)
      begin
        wd = line(w, e);
        wr({7'(e), 1'b0}, 2'(w), 1'b0);
      end
    for (int w = 0; w < 4; w++)
      for (int h = 0; h < 4; h++)
        rd({(h[1] ? 7'd127 : 7'd5), h[0]}, w, h[0]);
    wd = line(2, 5);
    wd[127:0] = ~wd[127:0];
    wd[143:128] = par16(wd[127:0]);
    wm = 16'h0FF0;
    wr(8'h0A, 2'h2, 1'b0);
    rd(8'h0A, 2, 1'b0);
    rd(8'h0B, 2, 1'b1);
    wd = line(1, 5);
    wd[131] = ~wd[131];
    wm = 16'h0008;
    wr(8'h0A, 2'h1, 1'b0);
    rd(8'h0A, 1, 1'b0);
    wd = '0;
    wm = 16'hFFFF;
    wr(8'h0A, 2'h3, 1'b1);
    rd(8'h0A, 3, 1'b0);
    acc(1'b1, 1'b1, 8'h0A, 2'h3, 4'h8, 1'b1, 1'b0, 1'b0);
    chk("clash_rdata", 64'h0, rdata);
    chk("clash_rparity", 8'h00, rpar);
    rd(8'h0A, 3, 1'b0);
    acc(1'b1, 1'b0, 8'h0A, 2'h0, 4'h0, 1'b0, 1'b0, 1'b0);
    chk("nosel_rdata", 64'h0, rdata);
    acc(1'b0, 1'b0, 8'h0A, 2'h0, 4'h1, 1'b0, 1'b0, 1'b0);
    chk("noop_rdata", 64'h0, rdata);
    pp = par16({64'h0, fd});
    acc(1'b1, 1'b0, 8'h0A, 2'h0, 4'h1, 1'b0, 1'b1, 1'b0);
    chk("bypass_rdata", fd, rdata);
    chk("bypass_rparity", pp[7:0], rpar);
    fd = ~fd;
    acc(1'b0, 1'b0, 8'h0A, 2'h0, 4'h0, 1'b0, 1'b1, 1'b0);
    chk("noop_bypass_rdata", fd, rdata);
    @(posedge clk_in);
    ace <= 1'b0;
    wr(8'h0A, 2'h0, 1'b0);
    @(posedge clk_in);
    ace <= 1'b1;
    rd(8'h0A, 0, 1'b0);
    @(posedge clk_in);
    {ace, wce, rce} <= 3'h0;
    ovr <= 1'b1;
    wd = line(3, 9);
    wr(8'h0A, 2'h0, 1'b0);
    rd(8'h0A, 0, 1'b0);
    @(posedge clk_in);
    {ace, wce, rce} <= 3'h7;
    ovr <= 1'b0;
    // Scanned array or held input collar must leave way 1 untouched
    @(posedge clk_in);
    ase <= 1'b1;
    wr(8'h0A, 2'h1, 1'b0);
    ase <= 1'b0;
    ics <= 1'b1;
    wr(8'h0A, 2'h1, 1'b0);
    ics <= 1'b0;
    rd(8'h0A, 1, 1'b0);
    rp(2'h1, 6'h2A, 2'h3, 1'b1, 1'b0);
    rp(2'h2, 6'h15, 2'h1, 1'b1, 1'b0);
    rp(2'h1, 6'h00, 2'h0, 1'b0, 1'b0);
    chk("repair_value", 6'h2A, rval);
    chk("repair_en", 2'h3, ren);
    rp(2'h2, 6'h00, 2'h0, 1'b0, 1'b0);
    chk("repair_value", 6'h15, rval);
    chk("repair_en", 2'h1, ren);
    rp(2'h1, 6'h00, 2'h0, 1'b0, 1'b1);
    rp(2'h1, 6'h00, 2'h0, 1'b0, 1'b0);
    chk("repair_value", 6'h00, rval);
    chk("repair_en", 2'h0, ren);
    results();
  end
endmodule
